// [design/twb_map.vh]
// Summary of operation
// R1 - Dir low: clock repeats master to slave.
// R2 - Dir high: clock repeats slave to master.
// R3 - One-way clock; masters avoid needing stretching.
// R4 - First data side below lock controls.
// R5 - Controlling side falling pulls other low.
// R6 - Lock holds until controller rises above unlock.
// R7 - Bus ports only pull low; pull-ups external.
// R8 - Enable high repeats; low isolates segments.
// R9 - Deassert enable only while bus idle.
// R10 - Enable and direction always actively driven.
// R11 - Enable buffers in sequence at start-up.
// R12 - Release other side once controller reads high.
// R13 - Disabled buffer releases ports, clears lock.
`ifndef TWB_MAP_VH
`define TWB_MAP_VH
// Settle time of 1000 ns, counted in 10 ns clock cycles.
`define TWB_SETTLE_CYC 16'h0064
// Quiet timeout of 50 us, counted in 10 ns clock cycles.
`define TWB_IDLE_CYC 16'h1388
`define TWB_ST_OFF 2'h0
`define TWB_ST_SETTLE 2'h1
`define TWB_ST_ON 2'h2
`define TWB_ST_DRAIN 2'h3
`define TWB_DIR_RESET 1'b0
`define TWB_EN_RESET 1'b0
`define TWB_IDLE_RESET 1'b0
`endif

// [design/twb_ctrl.v]
`timescale 1ns/1ps
`include "twb_map.vh"
module twb_ctrl #(
   parameter [15:0] IDLE_CYC = `TWB_IDLE_CYC
)(
   input wire ref_clk,
   input wire rst_n,
   input wire req_enable,
   input wire req_dir,
   input wire seg_ready,
   input wire scl_level,
   input wire sda_level,
   output reg buf_en,
   output reg buf_dir,
   output reg bus_idle,
   output wire en_active
);
   localparam [1:0] ST_OFF = `TWB_ST_OFF;
   localparam [1:0] ST_SETTLE = `TWB_ST_SETTLE;
   localparam [1:0] ST_ON = `TWB_ST_ON;
   localparam [1:0] ST_DRAIN = `TWB_ST_DRAIN;
   localparam [15:0] SETTLE_CYC = `TWB_SETTLE_CYC;
   // The settle count starts at zero on the first settle cycle.
   localparam [15:0] SETTLE_LAST = SETTLE_CYC - 16'h0001;

   reg [1:0] state;
   reg [1:0] next_state;
   reg [15:0] settle_cnt;
   reg [15:0] next_settle_cnt;
   reg [15:0] idle_cnt;
   reg [15:0] next_idle_cnt;
   reg scl_prev;
   reg sda_prev;
   reg busy;
   reg next_busy;
   reg next_bus_idle;
   reg next_buf_en;
   reg next_buf_dir;
   wire start_seen;
   wire stop_seen;
   wire quiet;
   wire timed_out;
   wire idle_now;
   wire dir_free;

   // True in the states in which the buffer is switched on.
   function state_enabled;
      input [1:0] st;
      begin
         state_enabled = (st == ST_ON) | (st == ST_DRAIN);
      end
   endfunction

   // Data turning away from a level while the clock stays high.
   function data_turn;
      input scl_now;
      input scl_old;
      input sda_old;
      input sda_now;
      input from_level;
      begin
         data_turn = scl_now & scl_old & (sda_old == from_level) & (sda_now != from_level);
      end
   endfunction

   // A start is data falling with clock high; a stop is data rising with clock high.
   assign start_seen = data_turn(scl_level, scl_prev, sda_prev, sda_level, 1'b1);
   assign stop_seen = data_turn(scl_level, scl_prev, sda_prev, sda_level, 1'b0);
   // R7 released lines read high
   assign quiet = scl_level & sda_level;
   // A long quiet spell also counts as idle, in case a stop was missed.
   assign timed_out = quiet & (idle_cnt >= IDLE_CYC);
   assign idle_now = quiet & (~busy | timed_out);
   assign en_active = state_enabled(state);
   // R3 no mid-transfer turn
   // Direction only moves while disabled or idle, so a clock edge is never cut.
   // Only the near segment is watched, so a transfer begun far away is not seen.
   assign dir_free = ~state_enabled(state) | (bus_idle & idle_now);

   // History starts at the idle high level, so that no false start follows reset.
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end
      else
      begin
         scl_prev <= scl_level;
         sda_prev <= sda_level;
      end
   end

   // The quiet counter saturates, so a long idle spell never wraps back to busy.
   always @*
   begin
      next_idle_cnt = idle_cnt;
      if (!quiet)
         next_idle_cnt = 16'h0000;
      else if (idle_cnt < IDLE_CYC)
         next_idle_cnt = idle_cnt + 16'h0001;
   end

   // Busy marks an open transfer from its start to its stop.
   always @*
   begin
      next_busy = busy;
      // A start wins over any clear in the same cycle.
      if (start_seen)
         next_busy = 1'b1;
      else if (stop_seen || timed_out)
         next_busy = 1'b0;
      next_bus_idle = idle_now & ~start_seen;
   end

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy <= 1'b0;
         idle_cnt <= 16'h0000;
         bus_idle <= `TWB_IDLE_RESET;
      end
      else
      begin
         busy <= next_busy;
         idle_cnt <= next_idle_cnt;
         bus_idle <= next_bus_idle;
      end
   end

   // An enable request passes through a settle phase before the pin goes high.
   always @*
   begin
      next_state = state;
      case (state)
         ST_OFF:
         begin
            // R11 staged bring-up
            if (req_enable && seg_ready)
               next_state = ST_SETTLE;
         end
         ST_SETTLE:
         begin
            // Losing either half of the request restarts the settle phase.
            if (!req_enable || !seg_ready)
               next_state = ST_OFF;
            else if (settle_cnt >= SETTLE_LAST)
               next_state = ST_ON;
         end
         ST_ON:
         begin
            // A dropped request drains first, since a cut transfer confuses the bus.
            if (!req_enable)
               next_state = ST_DRAIN;
         end
         ST_DRAIN:
         begin
            // R9 idle before disable
            if (req_enable)
               next_state = ST_ON;
            else if (bus_idle && idle_now)
               next_state = ST_OFF;
         end
         default:
         begin
            // An unused code falls back to off, which releases the buffer.
            next_state = ST_OFF;
         end
      endcase
   end

   // The settle counter runs only in its own state and restarts from zero otherwise.
   always @*
   begin
      if (state == ST_SETTLE)
         next_settle_cnt = settle_cnt + 16'h0001;
      else
         next_settle_cnt = 16'h0000;
   end

   always @*
   begin
      // R8 enable isolates segments
      next_buf_en = state_enabled(next_state);
      next_buf_dir = buf_dir;
      // R10 always driven levels
      if (dir_free)
         next_buf_dir = req_dir;
   end

   // State and settle count share one reset, so a reset mid-settle starts over.
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_OFF;
         settle_cnt <= 16'h0000;
      end
      else
      begin
         state <= next_state;
         settle_cnt <= next_settle_cnt;
      end
   end

   // Both pins are registered, so the buffer never sees a decode glitch.
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buf_en <= `TWB_EN_RESET;
         buf_dir <= `TWB_DIR_RESET;
      end
      else
      begin
         buf_en <= next_buf_en;
         buf_dir <= next_buf_dir;
      end
   end
endmodule // twb_ctrl

// [test/twb_properties.sv]
`timescale 1ns/1ps
module twb_chk(
   input wire ref_clk,
   input wire rst_n,
   input wire req_enable,
   input wire seg_ready,
   input wire bus_idle,
   input wire buf_en,
   input wire buf_dir
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_off; $fell(buf_en) |-> $past(bus_idle); endproperty
   a_off: assert property (p_off) else $error("off while busy");
   property p_on; $rose(buf_en) |-> $past(req_enable && seg_ready); endproperty
   a_on: assert property (p_on) else $error("on unasked");
   property p_dir; buf_en && !bus_idle |=> $stable(buf_dir); endproperty
   a_dir: assert property (p_dir) else $error("dir moved");
   property p_settle; $rose(buf_en) |-> $past(req_enable && seg_ready, 101); endproperty
   a_settle: assert property (p_settle) else $error("on before settle");
   property p_hold; buf_en && !bus_idle |=> buf_en; endproperty
   a_hold: assert property (p_hold) else $error("cut while busy");
   c_on: cover property ($rose(buf_en));
   c_off: cover property ($fell(buf_en));
   c_busy: cover property (buf_en && !bus_idle);
endmodule // twb_chk
bind twb_ctrl twb_chk u_chk(.*);

// [test/twb_dev_model.sv]
`timescale 1ns/1ps
module twb_dev_model(
   input wire en,
   input wire dir,
   input wire m_scl,
   input wire s_scl,
   input wire s_sda,
   input wire m_sda,
   output wire m_scl_bus,
   output wire m_sda_bus
);
   reg s_lock = 0;
   always @*
      s_lock = en && !s_sda && (s_lock || m_sda);
   assign m_scl_bus = m_scl && !(en && dir && !s_scl);
   assign m_sda_bus = m_sda && !s_lock;
endmodule // twb_dev_model

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
   reg ref_clk = 0, rst_n = 0, req_enable = 0, req_dir = 0, seg_ready = 1;
   reg m_scl = 1, m_sda = 1;
   wire scl_level, sda_level, buf_en, buf_dir, bus_idle, en_active;
   integer fail_count = 0, cmp_count = 0, i;
   always #5 ref_clk = ~ref_clk;
   twb_ctrl #(.IDLE_CYC(16'h0014)) u_dut(.ref_clk(ref_clk), .rst_n(rst_n),
      .req_enable(req_enable), .req_dir(req_dir), .seg_ready(seg_ready),
      .scl_level(scl_level), .sda_level(sda_level), .buf_en(buf_en),
      .buf_dir(buf_dir), .bus_idle(bus_idle), .en_active(en_active));
   twb_dev_model u_dev(.en(buf_en), .dir(buf_dir), .m_scl(m_scl), .s_scl(1'b1),
      .s_sda(1'b1), .m_sda(m_sda), .m_scl_bus(scl_level), .m_sda_bus(sda_level));
   task chk(input string n, input e, input g);
      cmp_count = cmp_count + 1;
      if (g !== e)
      begin
         fail_count = fail_count + 1;
         $display("wrong value %0s exp %b got %b", n, e, g);
      end
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task wait_en(input e);
      for (i = 0; i < 400 && buf_en !== e; i = i + 1)
         @(negedge ref_clk);
      if (i == 400)
      begin
         fail_count = fail_count + 1;
         report_and_stop;
      end
   endtask
   task t_dir;
      req_dir = 1;
      repeat (3) @(negedge ref_clk);
      chk("dir", 1'b1, buf_dir);
   endtask
   task t_ready;
      seg_ready = 0;
      req_enable = 1;
      repeat (150) @(negedge ref_clk);
      chk("not ready", 1'b0, buf_en);
      seg_ready = 1;
      repeat (50) @(negedge ref_clk);
      seg_ready = 0;
      repeat (100) @(negedge ref_clk);
      chk("cut settle", 1'b0, buf_en);
      chk("cut active", 1'b0, en_active);
   endtask
   task t_enable;
      req_enable = 1;
      seg_ready = 1;
      wait_en(1'b1);
      chk("settle", 1'b1, i == 101);
      chk("active", 1'b1, en_active);
   endtask
   task t_busy;
      m_sda = 0;
      repeat (2) @(negedge ref_clk);
      chk("busy", 1'b0, bus_idle);
      req_enable = 0;
      req_dir = 0;
      repeat (40) @(negedge ref_clk);
      chk("hold", 1'b1, buf_en);
      chk("dir held", 1'b1, buf_dir);
      m_sda = 1;
      wait_en(1'b0);
      chk("active", 1'b0, en_active);
      chk("idle", 1'b1, bus_idle);
      chk("dir free", 1'b0, buf_dir);
   endtask
   task t_timeout;
      req_enable = 1;
      wait_en(1'b1);
      m_sda = 0;
      repeat (2) @(negedge ref_clk);
      m_scl = 0;
      req_enable = 0;
      repeat (2) @(negedge ref_clk);
      m_sda = 1;
      repeat (2) @(negedge ref_clk);
      m_scl = 1;
      repeat (15) @(negedge ref_clk);
      chk("quiet hold", 1'b1, buf_en);
      chk("quiet busy", 1'b0, bus_idle);
      wait_en(1'b0);
      chk("timeout off", 1'b0, en_active);
   endtask
   initial
   begin
      repeat (5) @(negedge ref_clk);
      rst_n = 1;
      t_dir;
      t_ready;
      t_enable;
      t_busy;
      t_timeout;
      report_and_stop;
   end
endmodule // testbench
